// file: hw/spi_pin_and_control_logic.sv
/*
  Byte-wide serial peripheral interface: control registers, master clock
  generation, master and slave shifting, pin ownership and pin drivers.
  Assumes a simple register port with read data one cycle after the strobe,
  external pins joined by a pad ring that resolves the three-signal pins.
*/
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/10ps
module spi_pin_and_control_logic (
  input wire logic clk,
  input wire logic rst,
  input wire logic [spi_link_pkg::ADDR_W-1:0] regAddr,
  input wire logic [spi_link_pkg::DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [spi_link_pkg::DATA_W-1:0] regRdata,
  input wire logic sclkIn,
  output logic sclkOut,
  output logic sclkOeN,
  input wire logic mosiIn,
  output logic mosiOut,
  output logic mosiOeN,
  input wire logic misoIn,
  output logic misoOut,
  output logic misoOeN,
  input wire logic ssN,
  output logic sclkOwned,
  output logic mosiOwned,
  output logic misoOwned,
  output logic ssOwned,
  output logic pullupOff,
  output logic ssLevel,
  output logic txIrq,
  output logic rxIrq
);
  import spi_link_pkg::*;

  logic sclkSync;
  logic mosiSync;
  logic misoSync;
  logic ssSync;

  logic [DATA_W-1:0] control_q, control_d;
  logic mfEnable_q, mfEnable_d;
  logic [1:0] rate_q, rate_d;
  logic rxFull_q, rxFull_d;
  logic overflow_q, overflow_d;
  logic modeFault_q, modeFault_d;
  logic txFull_q, txFull_d;
  logic [DATA_W-1:0] txData_q, txData_d;
  logic [DATA_W-1:0] rxData_q, rxData_d;
  logic [DATA_W-1:0] shift_q, shift_d;
  logic outBit_q, outBit_d;
  logic [3:0] bitCnt_q, bitCnt_d;
  logic [3:0] edgeCnt_q, edgeCnt_d;
  logic [7:0] divCnt_q, divCnt_d;
  logic sclkLvl_q, sclkLvl_d;
  xfer_state_t state_q, state_d;
  logic ovfSeen_q, ovfSeen_d;
  logic modfSeen_q, modfSeen_d;
  logic [DATA_W-1:0] rdData_q, rdData_d;
  logic sclkPrev_q, ssPrev_q;
  logic sclkOut_d, sclkOeN_d, mosiOut_d, mosiOeN_d, misoOut_d, misoOeN_d;
  logic sclkOut_q, sclkOeN_q, mosiOut_q, mosiOeN_q, misoOut_q, misoOeN_q;

  logic enable, master, cpol, cpha, wiredOr;
  logic ssLow, slaveOn, slaveLead, slaveTrail, ssFall, ssRise;
  logic [7:0] divisor;
  logic halfTick;
  logic sampleEdge, launchEdge, byteDone, masterFault, slaveFault;

  // every pin input passes two flops; select idles high
  bit_sync #(.RESET_VAL(1'b0)) syncSclk (.clk(clk), .rst(rst), .din(sclkIn), .dout(sclkSync));
  bit_sync #(.RESET_VAL(1'b0)) syncMosi (.clk(clk), .rst(rst), .din(mosiIn), .dout(mosiSync));
  bit_sync #(.RESET_VAL(1'b0)) syncMiso (.clk(clk), .rst(rst), .din(misoIn), .dout(misoSync));
  bit_sync #(.RESET_VAL(1'b1)) syncSs (.clk(clk), .rst(rst), .din(ssN), .dout(ssSync));

  assign enable = control_q[CTL_ENABLE];
  assign master = control_q[CTL_MASTER];
  assign cpol = control_q[CTL_CPOL];
  assign cpha = control_q[CTL_CPHA];
  assign wiredOr = control_q[CTL_WIRED_OR];

  assign ssLow = ~ssSync;
  assign slaveOn = enable & ~master;
  // edges count only while selected; select high masks them
  assign slaveLead = slaveOn & ssLow & (sclkSync != sclkPrev_q) & (sclkSync != cpol);
  assign slaveTrail = slaveOn & ssLow & (sclkSync != sclkPrev_q) & (sclkSync == cpol);
  assign ssFall = ssPrev_q & ~ssSync;
  assign ssRise = ~ssPrev_q & ssSync;

  always_comb begin
    case (rate_q)
      2'h0: divisor = DIV_CODE0;
      2'h1: divisor = DIV_CODE1;
      2'h2: divisor = DIV_CODE2;
      default: divisor = DIV_CODE3;
    endcase
  end
  assign halfTick = (divCnt_q == divisor - 8'h01);

  assign masterFault = enable & master & mfEnable_q & ssLow;
  assign slaveFault = slaveOn & mfEnable_q & (state_q == XFER_BUSY) & ssRise;

  // open-drain only pulls low; push-pull drives both levels
  function automatic logic padOut(input logic val, input logic wom);
    padOut = wom ? 1'b0 : val;
  endfunction
  function automatic logic padOeN(input logic val, input logic drive, input logic wom);
    padOeN = ~(drive & (~wom | ~val));
  endfunction

  always_comb begin
    control_d = control_q;
    mfEnable_d = mfEnable_q;
    rate_d = rate_q;
    rxFull_d = rxFull_q;
    overflow_d = overflow_q;
    modeFault_d = modeFault_q;
    txFull_d = txFull_q;
    txData_d = txData_q;
    rxData_d = rxData_q;
    shift_d = shift_q;
    outBit_d = outBit_q;
    bitCnt_d = bitCnt_q;
    edgeCnt_d = edgeCnt_q;
    divCnt_d = divCnt_q;
    sclkLvl_d = sclkLvl_q;
    state_d = state_q;
    ovfSeen_d = ovfSeen_q;
    modfSeen_d = modfSeen_q;
    rdData_d = BYTE_ZERO;
    sampleEdge = 1'b0;
    launchEdge = 1'b0;
    byteDone = 1'b0;

    case (state_q)
      XFER_IDLE: begin
        sclkLvl_d = cpol;
        divCnt_d = 8'h00;
        bitCnt_d = 4'h0;
        edgeCnt_d = 4'h0;
        if (enable & master & txFull_q) begin
          shift_d = txData_q;
          outBit_d = txData_q[DATA_W-1];
          txFull_d = 1'b0;
          state_d = XFER_BUSY;
        end else if (slaveOn & ((~cpha & ssFall) | (cpha & slaveLead))) begin
          // without new data the previous shifter contents go out again
          if (txFull_q) begin
            shift_d = txData_q;
            outBit_d = txData_q[DATA_W-1];
            txFull_d = 1'b0;
          end else begin
            outBit_d = shift_q[DATA_W-1];
          end
          state_d = XFER_BUSY;
        end
      end
      XFER_BUSY: begin
        if (master) begin
          divCnt_d = divCnt_q + 8'h01;
          if (halfTick) begin
            divCnt_d = 8'h00;
            sclkLvl_d = ~sclkLvl_q;
            edgeCnt_d = edgeCnt_q + 4'h1;
            // even edge counts are leading edges
            sampleEdge = (edgeCnt_q[0] == cpha);
            launchEdge = ~sampleEdge;
            byteDone = (edgeCnt_q == EDGE_LAST);
          end
        end else begin
          sampleEdge = cpha ? slaveTrail : slaveLead;
          launchEdge = cpha ? slaveLead : slaveTrail;
          byteDone = sampleEdge & (bitCnt_q == BITS_PER_BYTE - 4'h1);
        end
        if (sampleEdge) begin
          shift_d = {shift_q[DATA_W-2:0], master ? misoSync : mosiSync};
          bitCnt_d = bitCnt_q + 4'h1;
        end
        if (launchEdge) begin
          outBit_d = shift_q[DATA_W-1];
        end
        if (byteDone) begin
          state_d = XFER_IDLE;
        end
      end
      default: begin
        state_d = XFER_IDLE;
      end
    endcase

    // register port
    if (regWrite) begin
      case (regAddr)
        ADDR_CONTROL: begin
          control_d = regWdata & CONTROL_WMASK;
        end
        ADDR_STATUS: begin
          mfEnable_d = regWdata[ST_MF_ENABLE];
          rate_d = regWdata[ST_RATE_HI:ST_RATE_LO];
        end
        ADDR_DATA: begin
          // a slave mid-byte keeps this waiting until the next start
          txData_d = regWdata;
          txFull_d = 1'b1;
          if (modfSeen_q) begin
            modeFault_d = 1'b0;
            modfSeen_d = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (regRead) begin
      case (regAddr)
        ADDR_CONTROL: begin
          rdData_d = control_q;
        end
        ADDR_STATUS: begin
          rdData_d[ST_RX_FULL] = rxFull_q;
          rdData_d[ST_OVERFLOW] = overflow_q;
          rdData_d[ST_MODE_FAULT] = modeFault_q;
          rdData_d[ST_TX_EMPTY] = ~txFull_q;
          rdData_d[ST_MF_ENABLE] = mfEnable_q;
          rdData_d[ST_RATE_HI:ST_RATE_LO] = rate_q;
          ovfSeen_d = overflow_q;
          modfSeen_d = modeFault_q;
        end
        ADDR_DATA: begin
          rdData_d = rxData_q;
          rxFull_d = 1'b0;
          if (ovfSeen_q) begin
            overflow_d = 1'b0;
            ovfSeen_d = 1'b0;
          end
        end
        default: begin
          rdData_d = BYTE_ZERO;
        end
      endcase
    end

    // a faulting master turns itself off
    if (masterFault) begin
      control_d[CTL_ENABLE] = 1'b0;
    end

    // disabled: partial reset that empties the transmit register; other flags and control bits untouched
    if (~enable) begin
      txFull_d = 1'b0;
      state_d = XFER_IDLE;
      shift_d = BYTE_ZERO;
      outBit_d = 1'b0;
      bitCnt_d = 4'h0;
      edgeCnt_d = 4'h0;
      divCnt_d = 8'h00;
      sclkLvl_d = cpol;
      byteDone = 1'b0;
    end

    // hardware sets win over software clears
    // a data read in the same cycle frees the register, so the byte is kept
    if (byteDone) begin
      if (rxFull_d) begin
        overflow_d = 1'b1;
      end else begin
        rxData_d = shift_d;
        rxFull_d = 1'b1;
      end
    end
    if (masterFault | slaveFault) begin
      modeFault_d = 1'b1;
    end
  end

  always_comb begin
    sclkOut_d = padOut(sclkLvl_q, wiredOr);
    sclkOeN_d = padOeN(sclkLvl_q, enable & master, wiredOr);
    mosiOut_d = padOut(outBit_q, wiredOr);
    mosiOeN_d = padOeN(outBit_q, enable & master, wiredOr);
    misoOut_d = padOut(outBit_q, wiredOr);
    misoOeN_d = padOeN(outBit_q, slaveOn & ssLow, wiredOr);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      control_q <= CONTROL_RESET;
      mfEnable_q <= MF_ENABLE_RESET;
      rate_q <= RATE_RESET;
      rxFull_q <= 1'b0;
      overflow_q <= 1'b0;
      modeFault_q <= 1'b0;
      txFull_q <= 1'b0;
      txData_q <= BYTE_ZERO;
      rxData_q <= BYTE_ZERO;
      shift_q <= BYTE_ZERO;
      outBit_q <= 1'b0;
      bitCnt_q <= 4'h0;
      edgeCnt_q <= 4'h0;
      divCnt_q <= 8'h00;
      sclkLvl_q <= 1'b0;
      state_q <= XFER_IDLE;
      ovfSeen_q <= 1'b0;
      modfSeen_q <= 1'b0;
      rdData_q <= BYTE_ZERO;
      sclkPrev_q <= 1'b0;
      ssPrev_q <= 1'b1;
      sclkOut_q <= 1'b0;
      sclkOeN_q <= 1'b1;
      mosiOut_q <= 1'b0;
      mosiOeN_q <= 1'b1;
      misoOut_q <= 1'b0;
      misoOeN_q <= 1'b1;
    end else begin
      control_q <= control_d;
      mfEnable_q <= mfEnable_d;
      rate_q <= rate_d;
      rxFull_q <= rxFull_d;
      overflow_q <= overflow_d;
      modeFault_q <= modeFault_d;
      txFull_q <= txFull_d;
      txData_q <= txData_d;
      rxData_q <= rxData_d;
      shift_q <= shift_d;
      outBit_q <= outBit_d;
      bitCnt_q <= bitCnt_d;
      edgeCnt_q <= edgeCnt_d;
      divCnt_q <= divCnt_d;
      sclkLvl_q <= sclkLvl_d;
      state_q <= state_d;
      ovfSeen_q <= ovfSeen_d;
      modfSeen_q <= modfSeen_d;
      rdData_q <= rdData_d;
      sclkPrev_q <= sclkSync;
      ssPrev_q <= ssSync;
      sclkOut_q <= sclkOut_d;
      sclkOeN_q <= sclkOeN_d;
      mosiOut_q <= mosiOut_d;
      mosiOeN_q <= mosiOeN_d;
      misoOut_q <= misoOut_d;
      misoOeN_q <= misoOeN_d;
    end
  end

  assign regRdata = rdData_q;
  assign sclkOut = sclkOut_q;
  assign sclkOeN = sclkOeN_q;
  assign mosiOut = mosiOut_q;
  assign mosiOeN = mosiOeN_q;
  assign misoOut = misoOut_q;
  assign misoOeN = misoOeN_q;
  // pins go back to the port whenever the block is off
  assign sclkOwned = enable;
  assign mosiOwned = enable;
  assign misoOwned = enable;
  assign ssOwned = enable & (~master | mfEnable_q);
  assign pullupOff = wiredOr;
  assign ssLevel = ssSync;
  assign txIrq = ~txFull_q & control_q[CTL_TX_IRQ_EN];
  assign rxIrq = rxFull_q & control_q[CTL_RX_IRQ_EN] & enable;
endmodule

// file: shared/spi_link_pkg.sv
/*
  Constants and types shared by the serial link control block: register map,
  field positions, reset values, rate divisors and the transfer states.
  Assumes a byte-wide register port with a two-bit word address.
*/
package spi_link_pkg;
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;

  // register word addresses
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_DATA = 2'h2;

  // serial_link_control fields
  localparam int CTL_RX_IRQ_EN = 7;
  localparam int CTL_MASTER = 5;
  localparam int CTL_CPOL = 4;
  localparam int CTL_CPHA = 3;
  localparam int CTL_WIRED_OR = 2;
  localparam int CTL_ENABLE = 1;
  localparam int CTL_TX_IRQ_EN = 0;
  localparam logic [DATA_W-1:0] CONTROL_RESET = 8'h28;
  localparam logic [DATA_W-1:0] CONTROL_WMASK = 8'hBF;

  // serial_link_status_control fields
  localparam int ST_RX_FULL = 7;
  localparam int ST_OVERFLOW = 6;
  localparam int ST_MODE_FAULT = 4;
  localparam int ST_TX_EMPTY = 3;
  localparam int ST_MF_ENABLE = 2;
  localparam int ST_RATE_HI = 1;
  localparam int ST_RATE_LO = 0;
  localparam logic MF_ENABLE_RESET = 1'b0;
  localparam logic [1:0] RATE_RESET = 2'h0;

  // master divisor per rate code; the serial clock toggles every divisor cycles
  localparam logic [7:0] DIV_CODE0 = 8'h02;
  localparam logic [7:0] DIV_CODE1 = 8'h08;
  localparam logic [7:0] DIV_CODE2 = 8'h20;
  localparam logic [7:0] DIV_CODE3 = 8'h80;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] EDGE_LAST = 4'hF;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;

  typedef enum logic {XFER_IDLE, XFER_BUSY} xfer_state_t;
endpackage

// file: hw/bit_sync.sv
/*
  Two-flop synchroniser for one level coming from a pin.
  Assumes the input is asynchronous to clk; reset is synchronous, active high.
*/
`timescale 1ns/10ps
module bit_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  logic stage1_q;
  logic stage1_d;
  logic stage2_d;

  always_comb begin
    stage1_d = din;
    stage2_d = stage1_q;
  end

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1_q <= RESET_VAL;
      dout <= RESET_VAL;
    end else begin
      stage1_q <= stage1_d;
      dout <= stage2_d;
    end
  end
endmodule

// file: tb/spi_link_properties.sv
/*
  Checker on the top-level ports of the serial link block.
  Assumes one clock clk and a synchronous active-high reset rst.
*/
`timescale 1ns/10ps
module spi_link_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic regRead,
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regRdata,
  input wire logic sclkOeN,
  input wire logic mosiOeN,
  input wire logic misoOeN,
  input wire logic ssN,
  input wire logic sclkOwned,
  input wire logic mosiOwned,
  input wire logic misoOwned,
  input wire logic ssOwned,
  input wire logic ssLevel,
  input wire logic rxIrq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // select held long enough to pass the two-flop sync
  sequence ssHeldLow;
    !ssN [*4];
  endsequence
  sequence ssHeldHigh;
    ssN [*5];
  endsequence

  a_read_idle_zero: assert property (!$past(regRead) || $past(regAddr) == 2'h3 |-> regRdata == 8'h00)
    else $error("read data not zero outside a read answer");
  a_owned_same: assert property (sclkOwned == mosiOwned && mosiOwned == misoOwned)
    else $error("pin ownership differs between clock and data pins");
  a_mosi_with_sclk: assert property (!mosiOeN |-> misoOeN && $past(sclkOwned))
    else $error("data out driven outside master mode");
  a_miso_slave_only: assert property (!misoOeN |-> $past(ssOwned) && sclkOeN)
    else $error("slave output driven outside slave mode");
  a_miso_release: assert property (ssHeldHigh |-> misoOeN)
    else $error("slave output driven with select high");
  a_pins_released: assert property (!sclkOwned [*3] |-> !ssOwned && sclkOeN && mosiOeN && misoOeN)
    else $error("pins still driven while disabled");
  a_rx_irq_gate: assert property (rxIrq |-> sclkOwned)
    else $error("receive request while disabled");
  a_ss_level: assert property ($stable(ssN) [*4] |-> ssLevel == ssN)
    else $error("select level not visible to the port");
  a_fault_release: assert property (ssOwned && !sclkOeN ##0 ssHeldLow |-> ##[0:6] !sclkOwned)
    else $error("master kept the pins after select went low");
endmodule

bind spi_pin_and_control_logic spi_link_properties chk (.clk(clk), .rst(rst), .regRead(regRead),
  .regAddr(regAddr), .regRdata(regRdata), .sclkOeN(sclkOeN), .mosiOeN(mosiOeN), .misoOeN(misoOeN),
  .ssN(ssN), .sclkOwned(sclkOwned), .mosiOwned(mosiOwned), .misoOwned(misoOwned), .ssOwned(ssOwned),
  .ssLevel(ssLevel), .rxIrq(rxIrq));

// file: tb/spi_far_slave.sv
/*
  Far-side slave for a block running as master, clock phase 1, idle-low clock.
  Assumes the bench pulses load with the reply byte before each frame.
*/
`timescale 1ns/10ps
module spi_far_slave (
  input wire logic sclk,
  input wire logic mosi,
  input wire logic load,
  input wire logic [7:0] reply,
  output logic miso,
  output logic [7:0] got,
  output logic [3:0] bits
);
  logic [7:0] sh;
  logic drv;

  // leading edge launches the next bit, msb first
  always @(posedge sclk or posedge load) begin
    if (load) begin
      sh = reply;
      drv = ~reply[7];
    end else begin
      drv = sh[7];
      sh = {sh[6:0], 1'b0};
    end
  end

  // trailing edge samples; eight of them make a byte
  always @(negedge sclk or posedge load) begin
    if (load) begin
      got = 8'h00;
      bits = 4'h0;
    end else begin
      got = {got[6:0], mosi};
      bits = bits + 4'h1;
    end
  end

  // line released after the frame: no pull, so show the inverse
  assign miso = (bits == 4'h8) ? ~drv : drv;
endmodule

// file: tb/tb.sv
/*
  Bench for the serial link block: reset values, control bits, a master
  frame against the far-side model, slave pin handling and mode fault.
  Assumes a 100 MHz clock and synchronous active-high reset.
*/
`timescale 1ns/10ps
module tb;
  import spi_link_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] regAddr = 2'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic ssN = 1'b1;
  logic extSclk = 1'b0;
  logic extMosi = 1'b0;
  logic load = 1'b0;
  logic [7:0] regRdata, farGot;
  logic [3:0] farBits;
  logic sclkOut, sclkOeN, mosiOut, mosiOeN, misoOut, misoOeN, farMiso;
  logic sclkOwned, mosiOwned, misoOwned, ssOwned, pullupOff, ssLevel, txIrq, rxIrq;
  logic sclkPin, mosiPin, misoPin;
  int fails = 0;
  int checksDone = 0;

  // each pin resolved from whoever has it enabled
  assign sclkPin = sclkOeN ? extSclk : sclkOut;
  assign mosiPin = mosiOeN ? extMosi : mosiOut;
  assign misoPin = misoOeN ? farMiso : misoOut;

  spi_pin_and_control_logic dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .sclkIn(sclkPin), .sclkOut(sclkOut),
    .sclkOeN(sclkOeN), .mosiIn(mosiPin), .mosiOut(mosiOut), .mosiOeN(mosiOeN), .misoIn(misoPin),
    .misoOut(misoOut), .misoOeN(misoOeN), .ssN(ssN), .sclkOwned(sclkOwned), .mosiOwned(mosiOwned),
    .misoOwned(misoOwned), .ssOwned(ssOwned), .pullupOff(pullupOff), .ssLevel(ssLevel),
    .txIrq(txIrq), .rxIrq(rxIrq));

  spi_far_slave far (.sclk(sclkPin), .mosi(mosiPin), .load(load), .reply(8'h3C), .miso(farMiso),
    .got(farGot), .bits(farBits));

  always #5 clk = ~clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checksDone++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    d = regRdata;
  endtask

  task automatic t_reset;
    logic [7:0] v;
    rd(ADDR_CONTROL, v);
    chk(v, 8'h28);
    rd(ADDR_STATUS, v);
    chk(v, 8'h08);
    rd(2'h3, v);
    chk(v, 8'h00);
    chk(8'({sclkOeN, mosiOeN, misoOeN, sclkOwned, ssOwned, txIrq, rxIrq, ssLevel}), 8'hE1);
    $display("reset values test done");
  endtask

  task automatic t_ctl;
    logic [7:0] v;
    wr(ADDR_CONTROL, 8'hFD);
    rd(ADDR_CONTROL, v);
    chk(v, 8'hBD);
    chk(8'({pullupOff, txIrq, sclkOwned}), 8'h06);
    wr(ADDR_CONTROL, 8'h28);
    @(negedge clk);
    chk(8'({pullupOff, txIrq}), 8'h00);
    $display("control bits test done");
  endtask

  task automatic t_master;
    logic [7:0] v;
    int n;
    wr(ADDR_STATUS, 8'h01);
    wr(ADDR_CONTROL, 8'hAA);
    load <= 1'b1;
    repeat (2) @(posedge clk);
    load <= 1'b0;
    @(negedge clk);
    chk(8'({sclkOwned, ssOwned, sclkOeN, mosiOeN, misoOeN}), 8'h11);
    wr(ADDR_DATA, 8'hA5);
    n = 0;
    while (sclkOut !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (sclkOut === 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk(n[7:0], 8'h08);
    n = 0;
    while (rxIrq !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk(8'(rxIrq), 8'h01);
    // pins lag the internal clock level by a cycle
    repeat (2) @(negedge clk);
    chk(farGot, 8'hA5);
    chk({4'h0, farBits}, 8'h08);
    chk(8'(sclkOut), 8'h00);
    rd(ADDR_DATA, v);
    chk(v, 8'h3C);
    wr(ADDR_CONTROL, 8'h28);
    $display("master frame test done");
  endtask

  task automatic t_slave;
    logic [7:0] v;
    wr(ADDR_CONTROL, 8'h02);
    wr(ADDR_DATA, 8'h96);
    repeat (4) @(negedge clk);
    chk(8'({ssOwned, sclkOeN, misoOeN}), 8'h07);
    @(posedge clk);
    ssN <= 1'b0;
    repeat (6) @(negedge clk);
    chk(8'({misoOeN, misoOut}), 8'h01);
    wr(ADDR_DATA, 8'h01);
    repeat (4) @(negedge clk);
    chk(8'({misoOut, ssLevel}), 8'h02);
    @(posedge clk);
    ssN <= 1'b1;
    repeat (6) @(negedge clk);
    chk(8'(misoOeN), 8'h01);
    rd(ADDR_STATUS, v);
    chk(8'(v[ST_MODE_FAULT]), 8'h00);
    wr(ADDR_CONTROL, 8'h28);
    $display("slave pins test done");
  endtask

  // phase 1, idle-high clock: the bench plays master on the pins
  task automatic t_slave_xfer;
    logic [7:0] v;
    logic [7:0] mo;
    logic [7:0] seen;
    mo = 8'h5A;
    seen = 8'h00;
    @(posedge clk);
    extSclk <= 1'b1;
    wr(ADDR_CONTROL, 8'h1A);
    wr(ADDR_DATA, 8'hC3);
    @(posedge clk);
    ssN <= 1'b0;
    repeat (6) @(posedge clk);
    for (int i = 7; i >= 0; i--) begin
      extSclk <= 1'b0;
      extMosi <= mo[i];
      repeat (7) @(posedge clk);
      @(negedge clk);
      seen = {seen[6:0], misoPin};
      @(posedge clk);
      extSclk <= 1'b1;
      repeat (8) @(posedge clk);
      if (i == 4) begin
        // deselected mid-byte: a clock pulse now must be ignored
        ssN <= 1'b1;
        repeat (4) @(posedge clk);
        extSclk <= 1'b0;
        repeat (4) @(posedge clk);
        extSclk <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk(8'(misoOeN), 8'h01);
        @(posedge clk);
        ssN <= 1'b0;
        repeat (6) @(posedge clk);
      end
    end
    rd(ADDR_STATUS, v);
    chk(v, 8'h89);
    rd(ADDR_DATA, v);
    chk(v, mo);
    chk(seen, 8'hC3);
    wr(ADDR_CONTROL, 8'h28);
    ssN <= 1'b1;
    extSclk <= 1'b0;
    $display("slave transfer test done");
  endtask

  task automatic t_fault;
    logic [7:0] v;
    wr(ADDR_STATUS, 8'h04);
    wr(ADDR_CONTROL, 8'h22);
    @(negedge clk);
    chk(8'({sclkOwned, ssOwned}), 8'h03);
    @(posedge clk);
    ssN <= 1'b0;
    repeat (8) @(negedge clk);
    chk(8'(sclkOwned), 8'h00);
    rd(ADDR_CONTROL, v);
    chk(v, 8'h20);
    rd(ADDR_STATUS, v);
    chk(8'(v[ST_MODE_FAULT]), 8'h01);
    @(posedge clk);
    ssN <= 1'b1;
    $display("mode fault test done");
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_ctl();
    t_master();
    t_slave();
    t_slave_xfer();
    t_fault();
    give_verdict();
  end

  // whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    give_verdict();
  end
endmodule
